/* rtl/compare_timer_channel.sv */
// Function
// - Compare B equality at a count tick sets the B flag, bit 7.
// - B flag clears by software zero write only after reading it as one.
// - Transfer controller activation by B request clears B flag when not disabled.
// - Compare A equality sets A flag, bit 6; read-one then write-zero clears.
// - Transfer controller activation by A request clears A flag when not disabled.
// - Counter wrapping from maximum to zero sets the wrap flag, bit 5.
// - Wrap flag clears only after being read as one, then written zero.
// - Flag bits accept only zero writes, and ones written change nothing.
// - Status bit 4 is reserved, always reads one, writes ignored.
// - On B match, bits 3-2 keep, lower, raise or toggle the output pin.
// - On A match, bits 1-0 keep, lower, raise or toggle the output pin.
// - Match is taken in the last equal state, at the next count tick.
// - Counter clears on A or B match as the clear selection says.
// - With external clearing, a rising reset input edge zeroes the counter.
// - Clock select picks off, divide by 8, 64, 8192, chain or external.
// - External codes 101, 110, 111 count rising, falling or both edges.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module compare_timer_channel (
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    input  wire logic                                   wb_cyc_i,
    input  wire logic                                   wb_stb_i,
    input  wire logic                                   wb_we_i,
    input  wire logic [compare_timer_pkg::ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                             wb_sel_i,
    input  wire logic [compare_timer_pkg::DATA_W-1:0]   wb_dat_i,
    output logic      [compare_timer_pkg::DATA_W-1:0]   wb_dat_o,
    output logic                                        wb_ack_o,
    input  wire logic                                   ext_clock_pin_i,
    input  wire logic                                   ext_reset_pin_i,
    input  wire logic                                   chain_event_i,
    input  wire compare_timer_pkg::transfer_ack_t       transfer_i,
    output logic                                        timer_output_pin_o,
    output logic                                        match_a_interrupt_o,
    output logic                                        match_b_interrupt_o
);
    import compare_timer_pkg::*;

    // ****************************************
    // State
    // ****************************************
    channel_control_t    channel_control;
    flags_t              flags;
    logic [REG_W-1:0]    up_counter;
    logic [REG_W-1:0]    compare_a_value;
    logic [REG_W-1:0]    compare_b_value;
    logic [2:0]          armed;
    logic                pin;
    logic                ext_reset_prev;
    logic [DATA_W-1:0]   read_data;

    channel_control_t    next_channel_control;
    flags_t              next_flags;
    logic [REG_W-1:0]    next_up_counter;
    logic [REG_W-1:0]    next_compare_a_value;
    logic [REG_W-1:0]    next_compare_b_value;
    logic [2:0]          next_armed;
    logic                next_pin;
    logic                next_ext_reset_prev;
    logic [DATA_W-1:0]   next_read_data;
    logic                next_ack;

    logic [SYNC_W-1:0]   pins_sync;
    logic                ext_clock_sync;
    logic                ext_reset_sync;
    logic                tick;
    logic                bus_req;
    logic                access_done;
    logic                low_write;
    logic                status_read_done;
    logic                status_write;
    logic                counter_write;
    logic                match_a;
    logic                match_b;
    logic                ext_reset_rise;
    logic                counter_clear;
    logic                wrap_event;
    logic [2:0]          sw_clear;
    logic [2:0]          flag_set;
    logic [2:0]          flag_clear;
    logic [2:0]          flag_now;
    output_action_t      action;

    pin_sync u_pin_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  ({ext_reset_pin_i, ext_clock_pin_i}),
        .sync_o (pins_sync)
    );

    assign ext_clock_sync = pins_sync[0];
    assign ext_reset_sync = pins_sync[1];

    tick_source u_tick_source (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .clock_select_i (channel_control.clock_select),
        .chain_event_i  (chain_event_i),
        .ext_clock_i    (ext_clock_sync),
        .tick_o         (tick)
    );

    // ****************************************
    // Bus decode
    // ****************************************
    // Writes land at the edge where the master samples ack
    assign bus_req          = wb_cyc_i & wb_stb_i;
    assign access_done      = bus_req & wb_ack_o;
    assign low_write        = access_done & wb_we_i & wb_sel_i[0];
    assign status_write     = low_write & (wb_adr_i == OFS_STATUS);
    assign counter_write    = low_write & (wb_adr_i == OFS_COUNTER);
    assign status_read_done = access_done & ~wb_we_i & (wb_adr_i == OFS_STATUS);

    // ****************************************
    // Compare, clear and wrap events
    // ****************************************
    // Equality is only acted on at a tick, so a match fires once per equal period
    assign match_a = tick & (up_counter == compare_a_value);
    assign match_b = tick & (up_counter == compare_b_value);
    assign ext_reset_rise = ext_reset_sync & ~ext_reset_prev;
    assign counter_clear =
        (match_a & (channel_control.clear_select == CLR_MATCH_A)) |
        (match_b & (channel_control.clear_select == CLR_MATCH_B)) |
        (ext_reset_rise & (channel_control.clear_select == CLR_EXT_RESET));
    // Clear beats bus write, bus write beats increment
    assign wrap_event = tick & (up_counter == COUNTER_MAX) & ~counter_clear & ~counter_write;

    // ****************************************
    // Flag set and clear
    // ****************************************
    assign flag_now = {flags.match_b_flag, flags.match_a_flag, flags.wrap_flag};
    assign flag_set = {match_b, match_a, wrap_event};
    // Software clears a flag only by writing zero to it while armed; transfer activations also clear A and B
    assign sw_clear = {3{status_write}} & ~wb_dat_i[MATCH_B_FLAG_BIT:FLAG_LSB] & armed;
    assign flag_clear = sw_clear | {transfer_i.ack_b & ~transfer_i.disable_sel_b,
                                    transfer_i.ack_a & ~transfer_i.disable_sel_a,
                                    1'b0};

    // Simultaneous A and B: the larger code wins, toggle over high over low
    always_comb begin
        action = ACT_KEEP;
        if (match_a) begin
            action = flags.match_a_action;
        end
        if (match_b && (flags.match_b_action > action)) begin
            action = flags.match_b_action;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_channel_control = channel_control;
        next_compare_a_value = compare_a_value;
        next_compare_b_value = compare_b_value;
        next_up_counter      = up_counter;
        next_flags           = flags;
        next_armed           = armed;
        next_pin             = pin;
        next_ext_reset_prev  = ext_reset_sync;
        next_ack             = bus_req & ~wb_ack_o;
        next_read_data       = wb_dat_o;

        if (low_write && (wb_adr_i == OFS_CONTROL)) begin
            next_channel_control = channel_control_t'(wb_dat_i[CTRL_W-1:0]);
        end
        if (low_write && (wb_adr_i == OFS_COMPARE_A)) begin
            next_compare_a_value = wb_dat_i[REG_W-1:0];
        end
        if (low_write && (wb_adr_i == OFS_COMPARE_B)) begin
            next_compare_b_value = wb_dat_i[REG_W-1:0];
        end

        if (counter_clear) begin
            next_up_counter = COUNTER_RESET;
        end else if (counter_write) begin
            next_up_counter = wb_dat_i[REG_W-1:0];
        end else if (tick) begin
            next_up_counter = up_counter + 8'h01;
        end

        if (status_write) begin
            next_flags.match_b_action = output_action_t'(wb_dat_i[3:2]);
            next_flags.match_a_action = output_action_t'(wb_dat_i[1:0]);
            next_armed = 3'b000;
        end
        if (status_read_done) begin
            next_armed = armed | wb_dat_o[MATCH_B_FLAG_BIT:FLAG_LSB];
        end
        // A set arriving with a clear wins
        {next_flags.match_b_flag, next_flags.match_a_flag, next_flags.wrap_flag} =
            (flag_now & ~flag_clear) | flag_set;

        unique case (action)
            ACT_KEEP:   next_pin = pin;
            ACT_LOW:    next_pin = 1'b0;
            ACT_HIGH:   next_pin = 1'b1;
            ACT_TOGGLE: next_pin = ~pin;
        endcase

        if (next_ack && !wb_we_i) begin
            unique case (wb_adr_i)
                OFS_CONTROL:   next_read_data = {27'h0, channel_control};
                OFS_STATUS:    next_read_data = {24'h0, flag_now, RESERVED_VALUE,
                                                 flags.match_b_action, flags.match_a_action};
                OFS_COUNTER:   next_read_data = {24'h0, up_counter};
                OFS_COMPARE_A: next_read_data = {24'h0, compare_a_value};
                OFS_COMPARE_B: next_read_data = {24'h0, compare_b_value};
                default:       next_read_data = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_control <= CONTROL_RESET;
            compare_a_value <= COMPARE_RESET;
            compare_b_value <= COMPARE_RESET;
            up_counter      <= COUNTER_RESET;
            flags           <= FLAGS_RESET;
            armed           <= 3'b000;
            pin             <= PIN_RESET;
            ext_reset_prev  <= 1'b0;
            wb_ack_o        <= 1'b0;
            wb_dat_o        <= '0;
        end else begin
            channel_control <= next_channel_control;
            compare_a_value <= next_compare_a_value;
            compare_b_value <= next_compare_b_value;
            up_counter      <= next_up_counter;
            flags           <= next_flags;
            armed           <= next_armed;
            pin             <= next_pin;
            ext_reset_prev  <= next_ext_reset_prev;
            wb_ack_o        <= next_ack;
            wb_dat_o        <= next_read_data;
        end
    end

    assign timer_output_pin_o  = pin;
    assign match_a_interrupt_o = flags.match_a_flag;
    assign match_b_interrupt_o = flags.match_b_flag;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    match_b_set_a: assert property (match_b |=> match_b_interrupt_o)
        else $error("B match did not set B flag");
    b_clear_cause_a: assert property ($fell(flags.match_b_flag) |->
        $past(armed[2] & status_write) || $past(transfer_i.ack_b & ~transfer_i.disable_sel_b))
        else $error("B flag cleared without cause");
    xfer_clear_b_a: assert property ((transfer_i.ack_b && !transfer_i.disable_sel_b && !match_b)
        |=> !flags.match_b_flag)
        else $error("Transfer activation did not clear B flag");
    match_a_set_a: assert property (match_a |=> match_a_interrupt_o)
        else $error("A match did not set A flag");
    xfer_clear_a_a: assert property ((transfer_i.ack_a && !transfer_i.disable_sel_a && !match_a)
        |=> !flags.match_a_flag)
        else $error("Transfer activation did not clear A flag");
    wrap_set_a: assert property (wrap_event |=> (flags.wrap_flag && up_counter == 8'h00))
        else $error("Wrap did not set flag or zero counter");
    wrap_unarmed_a: assert property ((status_write && !armed[0] && flags.wrap_flag)
        |=> flags.wrap_flag)
        else $error("Unarmed wrap flag was cleared");
    one_write_a: assert property ((status_write && wb_dat_i[WRAP_FLAG_BIT] && !flags.wrap_flag
        && !wrap_event) |=> !flags.wrap_flag)
        else $error("Writing one set wrap flag");
    reserved_one_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == OFS_STATUS)
        |-> wb_dat_o[RESERVED_BIT])
        else $error("Reserved status bit read zero");
    b_low_pin_a: assert property ((match_b && !match_a && flags.match_b_action == ACT_LOW)
        |=> !timer_output_pin_o)
        else $error("B match low action failed");
    a_toggle_pin_a: assert property ((match_a && !match_b && flags.match_a_action == ACT_TOGGLE)
        |=> timer_output_pin_o != $past(timer_output_pin_o))
        else $error("A match toggle action failed");
    match_on_tick_a: assert property ($rose(match_a_interrupt_o) |-> $past(tick))
        else $error("A flag set outside a count tick");
    b_on_tick_a: assert property ($rose(match_b_interrupt_o) |-> $past(tick))
        else $error("B flag set outside a count tick");
    pin_hold_a: assert property ((!match_a && !match_b) |=> $stable(timer_output_pin_o))
        else $error("Pin changed without a match");
    match_clear_a: assert property ((match_a && channel_control.clear_select == CLR_MATCH_A)
        |=> up_counter == 8'h00)
        else $error("Counter not cleared on A match");
    clear_on_b_a: assert property ((match_b && channel_control.clear_select == CLR_MATCH_B)
        |=> up_counter == 8'h00)
        else $error("Counter not cleared on B match");
    ext_clear_a: assert property ((ext_reset_rise && channel_control.clear_select == CLR_EXT_RESET)
        |=> up_counter == 8'h00)
        else $error("Counter not cleared on external reset edge");
    stop_hold_a: assert property ((channel_control.clock_select == CLK_OFF && !counter_write
        && !counter_clear) |=> $stable(up_counter))
        else $error("Counter moved while counting disabled");

endmodule

`default_nettype wire

/* rtl/compare_timer_pkg.sv */
package compare_timer_pkg;

    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;
    localparam int          REG_W         = 8;
    localparam logic [7:0]  OFS_CONTROL   = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_COUNTER   = 8'h08;
    localparam logic [7:0]  OFS_COMPARE_A = 8'h0c;
    localparam logic [7:0]  OFS_COMPARE_B = 8'h10;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int          MATCH_B_FLAG_BIT = 7;
    localparam int          MATCH_A_FLAG_BIT = 6;
    localparam int          WRAP_FLAG_BIT    = 5;
    localparam int          RESERVED_BIT     = 4;
    localparam int          FLAG_LSB         = 5;
    localparam int          CTRL_W           = 5;
    localparam logic [7:0]  COUNTER_RESET    = 8'h00;
    localparam logic [7:0]  COMPARE_RESET    = 8'hff;
    localparam logic [7:0]  COUNTER_MAX      = 8'hff;
    localparam logic        RESERVED_VALUE   = 1'b1;
    localparam logic        PIN_RESET        = 1'b0;

    // ****************************************
    // Prescaler taps and timing
    // ****************************************
    localparam int          PRESCALE_W   = 13;
    localparam int          DIV8_BITS    = 3;
    localparam int          DIV64_BITS   = 6;
    localparam int          DIV8192_BITS = 13;
    localparam int          SYNC_W       = 2;
    localparam int          CLK_PERIOD_PS = 5000;

    typedef enum logic [2:0] {
        CLK_OFF      = 3'b000,
        CLK_DIV8     = 3'b001,
        CLK_DIV64    = 3'b010,
        CLK_DIV8192  = 3'b011,
        CLK_CHAIN    = 3'b100,
        CLK_EXT_RISE = 3'b101,
        CLK_EXT_FALL = 3'b110,
        CLK_EXT_BOTH = 3'b111
    } clock_select_t;

    typedef enum logic [1:0] {
        CLR_NONE      = 2'b00,
        CLR_MATCH_A   = 2'b01,
        CLR_MATCH_B   = 2'b10,
        CLR_EXT_RESET = 2'b11
    } clear_select_t;

    typedef enum logic [1:0] {
        ACT_KEEP   = 2'b00,
        ACT_LOW    = 2'b01,
        ACT_HIGH   = 2'b10,
        ACT_TOGGLE = 2'b11
    } output_action_t;

    typedef struct packed {
        clear_select_t clear_select;
        clock_select_t clock_select;
    } channel_control_t;

    typedef struct packed {
        logic           match_b_flag;
        logic           match_a_flag;
        logic           wrap_flag;
        output_action_t match_b_action;
        output_action_t match_a_action;
    } flags_t;

    typedef struct packed {
        logic ack_b;
        logic disable_sel_b;
        logic ack_a;
        logic disable_sel_a;
    } transfer_ack_t;

    localparam channel_control_t CONTROL_RESET = '{CLR_NONE, CLK_OFF};
    localparam flags_t FLAGS_RESET = '{1'b0, 1'b0, 1'b0, ACT_KEEP, ACT_KEEP};

endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    input  wire logic [compare_timer_pkg::SYNC_W-1:0]   pin_i,
    output logic      [compare_timer_pkg::SYNC_W-1:0]   sync_o
);
    import compare_timer_pkg::*;

    logic [SYNC_W-1:0] stage_one;

    // ****************************************
    // Two flops per pin; first stage feeds only the second
    // ****************************************
    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                stage_one[i] <= 1'b0;
                sync_o[i]    <= 1'b0;
            end else begin
                stage_one[i] <= pin_i[i];
                sync_o[i]    <= stage_one[i];
            end
        end
    end

endmodule

`default_nettype wire

/* rtl/tick_source.sv */
`timescale 1ns/1ps
`default_nettype none

module tick_source (
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire compare_timer_pkg::clock_select_t clock_select_i,
    input  wire logic                            chain_event_i,
    input  wire logic                            ext_clock_i,
    output logic                                 tick_o
);
    import compare_timer_pkg::*;

    logic [PRESCALE_W-1:0] divider;
    logic [PRESCALE_W-1:0] next_divider;
    logic                  ext_prev;
    logic                  next_ext_prev;
    logic                  ext_rise;
    logic                  ext_fall;

    always_comb begin
        next_divider  = divider + 13'h0001;
        next_ext_prev = ext_clock_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divider  <= '0;
            ext_prev <= 1'b0;
        end else begin
            divider  <= next_divider;
            ext_prev <= next_ext_prev;
        end
    end

    assign ext_rise = ext_clock_i & ~ext_prev;
    assign ext_fall = ~ext_clock_i & ext_prev;

    // ****************************************
    // Count enable select
    // ****************************************
    // Divided clocks tick where their top tap would fall
    always_comb begin
        unique case (clock_select_i)
            CLK_OFF:      tick_o = 1'b0;
            CLK_DIV8:     tick_o = &divider[DIV8_BITS-1:0];
            CLK_DIV64:    tick_o = &divider[DIV64_BITS-1:0];
            CLK_DIV8192:  tick_o = &divider[DIV8192_BITS-1:0];
            CLK_CHAIN:    tick_o = chain_event_i;
            CLK_EXT_RISE: tick_o = ext_rise;
            CLK_EXT_FALL: tick_o = ext_fall;
            CLK_EXT_BOTH: tick_o = ext_rise | ext_fall;
        endcase
    end

endmodule

`default_nettype wire

/* tb/tb_compare_timer_channel.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_compare_timer_channel;
    import compare_timer_pkg::*;
    logic                clk_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                cyc = 1'b0;
    logic                stb = 1'b0;
    logic                we = 1'b0;
    logic [ADDR_W-1:0]   adr = '0;
    logic [3:0]          sel = '0;
    logic [DATA_W-1:0]   dat_w = '0;
    logic [DATA_W-1:0]   dat_r;
    logic                ack, ext_clk, ext_rst, chain, pin, irq_a, irq_b;
    transfer_ack_t       xfer;
    logic [7:0]          rd;
    int                  mismatches = 0;
    int                  total_checks = 0;

    always #2.5 clk_i = ~clk_i;

    compare_timer_channel compare_timer_channel_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .ext_clock_pin_i(ext_clk),
        .ext_reset_pin_i(ext_rst), .chain_event_i(chain), .transfer_i(xfer),
        .timer_output_pin_o(pin), .match_a_interrupt_o(irq_a), .match_b_interrupt_o(irq_b));
    timer_far_side timer_far_side_i (.clk_i(clk_i), .ext_clock_o(ext_clk),
        .ext_reset_o(ext_rst), .chain_o(chain), .transfer_o(xfer));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'h1};
        adr <= a;
        dat_w <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        rd = dat_r[7:0];
        {cyc, stb, we} <= 3'b000;
        if (n >= 100) mismatches++;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        wb(1'b0, a, 8'h00);
        check8(rd, exp, what);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_bits();
        rchk(OFS_STATUS, 8'h10, "status reset");
        rchk(OFS_COMPARE_A, 8'hff, "compare reset");
        wb(1'b1, OFS_STATUS, 8'hef);
        rchk(OFS_STATUS, 8'h1f, "ones ignored");
        $display("reset_bits done");
    endtask

    task automatic t_pulse();
        wb(1'b1, OFS_COMPARE_A, 8'h03);
        wb(1'b1, OFS_COMPARE_B, 8'h01);
        wb(1'b1, OFS_STATUS, 8'h06);
        wb(1'b1, OFS_CONTROL, 8'h0c);
        repeat (3) timer_far_side_i.tick();
        rchk(OFS_STATUS, 8'h96, "A not before tick");
        timer_far_side_i.tick();
        check8({7'h0, pin}, 8'h01, "pin high on A");
        rchk(OFS_COUNTER, 8'h00, "clear on A");
        repeat (2) timer_far_side_i.tick();
        check8({7'h0, pin}, 8'h00, "pin low on B");
        wb(1'b1, OFS_CONTROL, 8'h00);
        $display("pulse done");
    endtask

    task automatic t_flag_clear();
        wb(1'b1, OFS_STATUS, 8'hc6);
        wb(1'b1, OFS_STATUS, 8'h06);
        rchk(OFS_STATUS, 8'hd6, "unarmed kept");
        wb(1'b1, OFS_STATUS, 8'h06);
        rchk(OFS_STATUS, 8'h16, "armed cleared");
        wb(1'b1, OFS_CONTROL, 8'h04);
        wb(1'b1, OFS_COUNTER, 8'hff);
        timer_far_side_i.tick();
        rchk(OFS_STATUS, 8'h36, "wrap set");
        rchk(OFS_COUNTER, 8'h00, "wrapped");
        wb(1'b1, OFS_STATUS, 8'h06);
        rchk(OFS_STATUS, 8'h16, "wrap cleared");
        $display("flag_clear done");
    endtask

    task automatic t_transfer();
        wb(1'b1, OFS_COUNTER, 8'h03);
        timer_far_side_i.tick();
        check8({7'h0, irq_a}, 8'h01, "A set");
        timer_far_side_i.grant(1'b0, 1'b1);
        check8({7'h0, irq_a}, 8'h01, "A kept");
        timer_far_side_i.grant(1'b0, 1'b0);
        check8({7'h0, irq_a}, 8'h00, "A by transfer");
        wb(1'b1, OFS_COUNTER, 8'h01);
        timer_far_side_i.tick();
        check8({7'h0, irq_b}, 8'h01, "B set");
        timer_far_side_i.grant(1'b1, 1'b0);
        check8({7'h0, irq_b}, 8'h00, "B by transfer");
        $display("transfer done");
    endtask

    task automatic t_external();
        wb(1'b1, OFS_CONTROL, 8'h18);
        wb(1'b1, OFS_COUNTER, 8'h40);
        timer_far_side_i.ext_clear();
        repeat (6) @(posedge clk_i);
        rchk(OFS_COUNTER, 8'h00, "ext clear");
        for (int c = 5; c <= 7; c++) begin
            wb(1'b1, OFS_CONTROL, 8'(c));
            wb(1'b1, OFS_COUNTER, 8'h00);
            timer_far_side_i.ext_pulses(2);
            repeat (8) @(posedge clk_i);
            rchk(OFS_COUNTER, (c == 7) ? 8'h04 : 8'h02, "ext edges");
        end
        $display("external done");
    endtask

    // Any 128 consecutive edges hold exactly 16 divide-by-8 and 2 divide-by-64 ticks
    task automatic t_prescale();
        logic p;
        wb(1'b1, OFS_STATUS, 8'h03);
        p = pin;
        for (int c = 1; c <= 2; c++) begin
            wb(1'b1, OFS_CONTROL, 8'(c));
            wb(1'b1, OFS_COUNTER, 8'h00);
            repeat (127) @(posedge clk_i);
            rchk(OFS_COUNTER, (c == 1) ? 8'h10 : 8'h02, "divided count");
        end
        check8({7'h0, pin}, {7'h0, ~p}, "A toggle");
        wb(1'b1, OFS_CONTROL, 8'h14);
        wb(1'b1, OFS_COUNTER, 8'h00);
        repeat (2) timer_far_side_i.tick();
        rchk(OFS_COUNTER, 8'h00, "clear on B");
        $display("prescale done");
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_bits();
        t_pulse();
        t_flag_clear();
        t_transfer();
        t_external();
        t_prescale();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        complete_run();
    end
endmodule

`default_nettype wire

/* tb/timer_far_side.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_far_side
    import compare_timer_pkg::*;
(
    input  wire logic    clk_i,
    output logic          ext_clock_o,
    output logic          ext_reset_o,
    output logic          chain_o,
    output transfer_ack_t transfer_o
);
    initial begin
        ext_clock_o = 1'b0;
        ext_reset_o = 1'b0;
        chain_o = 1'b0;
        transfer_o = '0;
    end

    task automatic tick();
        @(posedge clk_i);
        chain_o <= 1'b1;
        @(posedge clk_i);
        chain_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // Four clocks per level, well above the 2.5 state minimum
    task automatic ext_pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_i);
            ext_clock_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            ext_clock_o <= 1'b0;
        end
    endtask

    task automatic ext_clear();
        @(posedge clk_i);
        ext_reset_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext_reset_o <= 1'b0;
    endtask

    task automatic grant(input logic on_b, input logic keep);
        @(posedge clk_i);
        if (on_b) transfer_o <= transfer_ack_t'{1'b1, keep, 1'b0, 1'b0};
        else transfer_o <= transfer_ack_t'{1'b0, 1'b0, 1'b1, keep};
        @(posedge clk_i);
        transfer_o <= '0;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire
